// ==== rtl/upds_top.v ====
// Serial port pin control, data path, status flags and Wishbone registers.
`timescale 1ns/100ps
`default_nettype none
`include "upds_defs.vh"
module upds_top (
    input wire REF_CLK,
    input wire RST_B,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output reg INT_O,
    input wire RX_I,
    output reg TX_O,
    output reg TX_OE,
    output reg TX_PULLUP_EN,
    output reg RX_PULLUP_EN,
    output reg SYNC_FUNC_EN,
    output reg [2:0] SYNC_MODE
);
    localparam TX_IDLE = 5'h01;
    localparam TX_START = 5'h02;
    localparam TX_DATA = 5'h04;
    localparam TX_PAR = 5'h08;
    localparam TX_STOP = 5'h10;

    function hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            hit = (adr[7:2] == off[7:2]);
        end
    endfunction

    reg [7:0] mode_q, ctl1_q, ctl2_q, baud_q, bcnt_q;
    reg [1:0] pull_q;
    reg [3:0] irq_st_q, irq_mask_q, flg_prev_q, ttc_q, tidx_q;
    reg rx_s1_q, rx_s2_q;
    reg perr_q, nerr_q, ferr_q, oerr_q, rxif_q, txif_q, tidle_q, armed_q, tpar_q, tline_q;
    reg [8:0] rxd_q, txh_q, tsh_q;
    reg [4:0] tst_q;
    reg [31:0] rdata;

    wire rx_valid, rx_perr, rx_ferr, rx_nerr, ridle;
    wire [8:0] rx_word;

    wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wr = req & WB_WE_I & WB_SEL_I[0];
    wire rd = req & ~WB_WE_I;
    wire async_mode_select = mode_q[`UPDS_MODE_ASYNC];
    wire port_en = ctl1_q[`UPDS_C1_EN];
    wire act = async_mode_select & port_en;
    wire tx_on = act & ctl2_q[`UPDS_C2_TXEN];
    wire rx_on = act & ctl2_q[`UPDS_C2_RXEN];
    // Serial registers answer only in asynchronous mode.
    wire ser_acc = req & async_mode_select;
    wire stat_rd = rd & async_mode_select & hit(WB_ADR_I, `UPDS_ADR_STAT);
    wire data_hit = ser_acc & hit(WB_ADR_I, `UPDS_ADR_DATA);
    wire data_acc = data_hit & (~WB_WE_I | WB_SEL_I[0]);
    wire data_rd = data_hit & ~WB_WE_I;
    wire data_wr = data_hit & WB_WE_I & WB_SEL_I[0];
    wire tick = act & (bcnt_q == baud_q);
    wire tbit_end = tick && (ttc_q == `UPDS_OVS_LAST);
    wire [3:0] tlast = ctl1_q[`UPDS_C1_NINE] ? `UPDS_BITS_9 : `UPDS_BITS_8;
    wire brk = ctl1_q[`UPDS_C1_BRK];
    wire rx_room = ~oerr_q & (~rxif_q | (data_rd & armed_q));
    wire [7:0] stat = {perr_q, nerr_q, ferr_q, oerr_q, ridle, rxif_q, tidle_q, txif_q};
    wire [3:0] flg_now = {oerr_q, rxif_q, tidle_q, txif_q};
    wire [3:0] flg_rise = flg_now & ~flg_prev_q;

    upds_rx u_rx (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .tick(tick),
        .rx(rx_s2_q),
        .enable(rx_on),
        .nine_bit(ctl1_q[`UPDS_C1_NINE]),
        .par_en(ctl1_q[`UPDS_C1_PEN]),
        .par_odd(ctl1_q[`UPDS_C1_PODD]),
        .word_valid_q(rx_valid),
        .word_q(rx_word),
        .perr_q(rx_perr),
        .ferr_q(rx_ferr),
        .nerr_q(rx_nerr),
        .idle_q(ridle)
    );

    // The pin is asynchronous, so it passes two flops before the receiver.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= RX_I;
            rx_s2_q <= rx_s1_q;
        end
    end

    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bcnt_q <= 8'h00;
        end else if (!act || bcnt_q == baud_q) begin
            bcnt_q <= 8'h00;
        end else begin
            bcnt_q <= bcnt_q + 8'h01;
        end
    end

    // Control registers; disabling the port drops the direction and break bits.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_q <= `UPDS_MODE_RST;
            ctl1_q <= `UPDS_CTL_RST;
            ctl2_q <= `UPDS_CTL_RST;
            baud_q <= `UPDS_BAUD_RST;
            pull_q <= `UPDS_PULL_RST;
            irq_mask_q <= 4'h0;
        end else begin
            if (wr && hit(WB_ADR_I, `UPDS_ADR_MODE)) begin
                mode_q <= WB_DAT_I[7:0];
            end
            if (wr && hit(WB_ADR_I, `UPDS_ADR_PULL)) begin
                pull_q <= WB_DAT_I[1:0];
            end
            if (wr && hit(WB_ADR_I, `UPDS_ADR_IRQM)) begin
                irq_mask_q <= WB_DAT_I[3:0];
            end
            if (wr && async_mode_select && hit(WB_ADR_I, `UPDS_ADR_CTL1)) begin
                ctl1_q <= WB_DAT_I[7:0];
            end
            if (wr && async_mode_select && hit(WB_ADR_I, `UPDS_ADR_CTL2)) begin
                ctl2_q <= WB_DAT_I[7:0];
            end
            if (wr && async_mode_select && hit(WB_ADR_I, `UPDS_ADR_BAUD)) begin
                baud_q <= WB_DAT_I[7:0];
            end
            if (!port_en) begin
                ctl2_q[`UPDS_C2_TXEN] <= 1'b0;
                ctl2_q[`UPDS_C2_RXEN] <= 1'b0;
                ctl1_q[`UPDS_C1_BRK] <= 1'b0;
            end
        end
    end

    // Receive flags: transfers and their error flags land in one cycle.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            perr_q <= 1'b0;
            nerr_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
            rxif_q <= 1'b0;
            rxd_q <= 9'h000;
            armed_q <= 1'b0;
        end else if (!act) begin
            perr_q <= 1'b0;
            nerr_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
            rxif_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            if (stat_rd) begin
                armed_q <= 1'b1;
            end else if (data_acc) begin
                armed_q <= 1'b0;
            end
            if (data_acc && armed_q) begin
                perr_q <= 1'b0;
                nerr_q <= 1'b0;
                ferr_q <= 1'b0;
                oerr_q <= 1'b0;
            end
            if (data_rd && armed_q) begin
                rxif_q <= 1'b0;
            end
            // New events come after the clears so a set is never lost.
            if (rx_valid) begin
                if (rx_room) begin
                    rxd_q <= rx_word;
                    rxif_q <= 1'b1;
                    perr_q <= rx_perr;
                    nerr_q <= rx_nerr;
                    ferr_q <= rx_ferr;
                end else begin
                    oerr_q <= 1'b1;
                end
            end
        end
    end

    // Transmit: holding register feeds the shifter, LSB first.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tst_q <= TX_IDLE;
            ttc_q <= 4'h0;
            tidx_q <= 4'h0;
            tsh_q <= 9'h000;
            txh_q <= 9'h000;
            tpar_q <= 1'b0;
            tline_q <= 1'b1;
            txif_q <= 1'b1;
            tidle_q <= 1'b1;
        end else if (!tx_on) begin
            tst_q <= TX_IDLE;
            tline_q <= 1'b1;
            txif_q <= 1'b1;
            tidle_q <= 1'b1;
        end else begin
            if (tick && tst_q != TX_IDLE) begin
                ttc_q <= ttc_q + 4'h1;
            end
            case (tst_q)
                TX_IDLE: begin
                    tline_q <= ~brk;
                    if (!txif_q && !brk) begin
                        tsh_q <= txh_q;
                        txif_q <= 1'b1;
                        tpar_q <= 1'b0;
                        ttc_q <= 4'h0;
                        tst_q <= TX_START;
                    end else if (txif_q && !brk) begin
                        tidle_q <= 1'b1;
                    end
                end
                TX_START: begin
                    tline_q <= 1'b0;
                    if (tbit_end) begin
                        tidx_q <= 4'h0;
                        tst_q <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    tline_q <= tsh_q[0];
                    if (tbit_end) begin
                        tsh_q <= {1'b0, tsh_q[8:1]};
                        tpar_q <= tpar_q ^ tsh_q[0];
                        tidx_q <= tidx_q + 4'h1;
                        if (tidx_q == tlast) begin
                            tidx_q <= 4'h0;
                            tst_q <= ctl1_q[`UPDS_C1_PEN] ? TX_PAR : TX_STOP;
                        end
                    end
                end
                TX_PAR: begin
                    tline_q <= tpar_q ^ ctl1_q[`UPDS_C1_PODD];
                    if (tbit_end) begin
                        tst_q <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    tline_q <= 1'b1;
                    if (tbit_end) begin
                        if (ctl1_q[`UPDS_C1_STOP2] && tidx_q == 4'h0) begin
                            tidx_q <= 4'h1;
                        end else begin
                            tst_q <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tst_q <= TX_IDLE;
                end
            endcase
            // A write lands last so it wins over a load in the same cycle.
            if (data_wr) begin
                txh_q <= {ctl1_q[`UPDS_C1_TX8], WB_DAT_I[7:0]};
                txif_q <= 1'b0;
                tidle_q <= 1'b0;
            end
        end
    end

    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flg_prev_q <= `UPDS_FLG_RST;
        end else begin
            flg_prev_q <= flg_now;
        end
    end

    // Sticky events: overrun, data available, tx idle, tx empty.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
            always @(posedge REF_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    irq_st_q[gi] <= 1'b0;
                end else if (flg_rise[gi]) begin
                    irq_st_q[gi] <= 1'b1;
                end else if (wr && hit(WB_ADR_I, `UPDS_ADR_IRQS) && WB_DAT_I[gi]) begin
                    irq_st_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Only the shared data location is mapped; the shifters never are.
    always @* begin
        rdata = 32'h00000000;
        if (hit(WB_ADR_I, `UPDS_ADR_MODE)) begin
            rdata[7:0] = mode_q;
        end else if (hit(WB_ADR_I, `UPDS_ADR_PULL)) begin
            rdata[1:0] = pull_q;
        end else if (hit(WB_ADR_I, `UPDS_ADR_IRQS)) begin
            rdata[3:0] = irq_st_q;
        end else if (hit(WB_ADR_I, `UPDS_ADR_IRQM)) begin
            rdata[3:0] = irq_mask_q;
        end else if (async_mode_select) begin
            if (hit(WB_ADR_I, `UPDS_ADR_STAT)) begin
                rdata[7:0] = stat;
            end else if (hit(WB_ADR_I, `UPDS_ADR_CTL1)) begin
                rdata[7:0] = {ctl1_q[7:2], rxd_q[8], 1'b0};
            end else if (hit(WB_ADR_I, `UPDS_ADR_CTL2)) begin
                rdata[7:0] = ctl2_q;
            end else if (hit(WB_ADR_I, `UPDS_ADR_DATA)) begin
                rdata[7:0] = rxd_q[7:0];
            end else if (hit(WB_ADR_I, `UPDS_ADR_BAUD)) begin
                rdata[7:0] = baud_q;
            end
        end
    end

    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
            INT_O <= 1'b0;
        end else begin
            WB_ACK_O <= req;
            WB_DAT_O <= rd ? rdata : 32'h00000000;
            INT_O <= |(irq_st_q & irq_mask_q);
        end
    end

    // Pins float and hand pull-high back to the general control when off.
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            TX_O <= 1'b1;
            TX_OE <= 1'b0;
            TX_PULLUP_EN <= 1'b0;
            RX_PULLUP_EN <= 1'b0;
            SYNC_FUNC_EN <= 1'b0;
            SYNC_MODE <= 3'h7;
        end else begin
            TX_O <= tx_on ? tline_q : 1'b1;
            TX_OE <= tx_on;
            TX_PULLUP_EN <= tx_on ? 1'b0 : pull_q[0];
            RX_PULLUP_EN <= rx_on ? 1'b0 : pull_q[1];
            SYNC_FUNC_EN <= ~async_mode_select & mode_q[`UPDS_MODE_SYNC_EN];
            SYNC_MODE <= async_mode_select ? 3'h0 : mode_q[7:5];
        end
    end
endmodule // upds_top
`default_nettype wire

// ==== rtl/upds_defs.vh ====
// Constants for the serial port pin, data path and status block.
// Functional notes
// - Mode, port and direction enables on: drive TX, take RX, drop pull-highs.
// - Any of those enables off: pin floats, pull-high follows general I/O control.
// - Written byte moves to transmit shifter, sent LSB first at baud rate.
// - RX shifted in LSB first at baud rate, finished word goes to data register.
// - Shift registers have no address; only the shared data register is mapped.
// - One data location: writes feed transmit, reads return received data.
// - Mode control bit 4 selects: 0 synchronous functions, 1 asynchronous port.
// - Serial port registers exist only while the mode select bit is 1.
// - Mode bits 7..5 (reset 111) and bit 1 act only while mode select is 0.
// - Status is read-only; reset: errors 0, rx idle 1, rx avail 0, tx flags 1.
// - Status bit 7 flags wrong parity, checked only with parity enabled.
// - Status bit 6 flags noise, set with rx available, never on overrun.
// - Status bit 5 flags a framing error on the received character.
// - Status bit 4 flags overrun and blocks further transfers while set.
// - Status read then a data read or a byte-0 data write clears the four error flags.
// - Receive idle reads 0 from start detection until stop bit completes.
// - Parity, framing and noise flags set in the word's transfer cycle.
`ifndef UPDS_DEFS_VH
`define UPDS_DEFS_VH
`define UPDS_ADR_MODE 8'h00
`define UPDS_ADR_STAT 8'h04
`define UPDS_ADR_CTL1 8'h08
`define UPDS_ADR_CTL2 8'h0C
`define UPDS_ADR_DATA 8'h10
`define UPDS_ADR_BAUD 8'h14
`define UPDS_ADR_IRQS 8'h18
`define UPDS_ADR_IRQM 8'h1C
`define UPDS_ADR_PULL 8'h20
`define UPDS_MODE_RST 8'hE0
`define UPDS_CTL_RST 8'h00
`define UPDS_BAUD_RST 8'h00
`define UPDS_PULL_RST 2'h0
`define UPDS_MODE_ASYNC 4
`define UPDS_MODE_SYNC_EN 1
`define UPDS_C1_EN 7
`define UPDS_C1_NINE 6
`define UPDS_C1_PEN 5
`define UPDS_C1_PODD 4
`define UPDS_C1_STOP2 3
`define UPDS_C1_BRK 2
`define UPDS_C1_TX8 0
`define UPDS_C2_TXEN 7
`define UPDS_C2_RXEN 6
`define UPDS_FLG_RST 4'h3
`define UPDS_OVS_LAST 4'hF
`define UPDS_OVS_HALF 4'h7
`define UPDS_SMP_A 4'h7
`define UPDS_SMP_C 4'h9
`define UPDS_BITS_8 4'h7
`define UPDS_BITS_9 4'h8
`endif

// ==== rtl/upds_rx.v ====
// Receive shifter with oversampled start detection and error checks.
`timescale 1ns/100ps
`default_nettype none
`include "upds_defs.vh"
module upds_rx (
    input wire clk,
    input wire rst_b,
    input wire tick,
    input wire rx,
    input wire enable,
    input wire nine_bit,
    input wire par_en,
    input wire par_odd,
    output reg word_valid_q,
    output reg [8:0] word_q,
    output reg perr_q,
    output reg ferr_q,
    output reg nerr_q,
    output reg idle_q
);
    localparam ST_IDLE = 5'h01;
    localparam ST_START = 5'h02;
    localparam ST_DATA = 5'h04;
    localparam ST_PAR = 5'h08;
    localparam ST_STOP = 5'h10;

    reg [4:0] state_q;
    reg [3:0] tcnt_q;
    reg [3:0] idx_q;
    reg [2:0] smp_q;
    reg [8:0] sh_q;
    reg par_q;
    reg noise_q;
    wire bit_end = tick && (tcnt_q == `UPDS_OVS_LAST);
    wire bit_val = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
    wire bit_noisy = ~(&smp_q) & (|smp_q);
    wire [3:0] last_idx = nine_bit ? `UPDS_BITS_9 : `UPDS_BITS_8;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            tcnt_q <= 4'h0;
            idx_q <= 4'h0;
            smp_q <= 3'h7;
            sh_q <= 9'h000;
            par_q <= 1'b0;
            noise_q <= 1'b0;
            word_valid_q <= 1'b0;
            word_q <= 9'h000;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            nerr_q <= 1'b0;
            idle_q <= 1'b1;
        end else if (!enable) begin
            state_q <= ST_IDLE;
            word_valid_q <= 1'b0;
            idle_q <= 1'b1;
        end else begin
            word_valid_q <= 1'b0;
            if (tick && state_q != ST_IDLE) begin
                tcnt_q <= tcnt_q + 4'h1;
                if (tcnt_q >= `UPDS_SMP_A && tcnt_q <= `UPDS_SMP_C) begin
                    smp_q <= {rx, smp_q[2:1]};
                end
            end
            // Three mid-bit samples vote; disagreement marks the word noisy.
            if (bit_end && bit_noisy) begin
                noise_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (tick && !rx) begin
                        state_q <= ST_START;
                        tcnt_q <= 4'h0;
                        noise_q <= 1'b0;
                        par_q <= 1'b0;
                        idx_q <= 4'h0;
                        idle_q <= 1'b0;
                    end
                end
                ST_START: begin
                    if (bit_end) begin
                        if (bit_val) begin
                            state_q <= ST_IDLE;
                            idle_q <= 1'b1;
                        end else begin
                            state_q <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (bit_end) begin
                        sh_q <= {bit_val, sh_q[8:1]};
                        par_q <= par_q ^ bit_val;
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == last_idx) begin
                            state_q <= par_en ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (bit_end) begin
                        par_q <= par_q ^ bit_val ^ par_odd;
                        state_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (bit_end) begin
                        state_q <= ST_IDLE;
                        idle_q <= 1'b1;
                        word_valid_q <= 1'b1;
                        word_q <= nine_bit ? sh_q : {1'b0, sh_q[8:1]};
                        perr_q <= par_en & par_q;
                        ferr_q <= ~bit_val;
                        nerr_q <= noise_q | bit_noisy;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    idle_q <= 1'b1;
                end
            endcase
        end
    end
endmodule // upds_rx
`default_nettype wire

// ==== testbench/upds_peer.sv ====
// Far-end serial device: sends frames on RX and captures frames from TX.
`timescale 1ns/100ps
`default_nettype none
module upds_peer #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk,
    input wire logic tx,
    output logic rx
);
    initial rx = 1'h1;
    task automatic send(input logic [7:0] d, input logic use_par, input logic par, input logic stop);
        int i;
        @(posedge clk);
        rx <= 1'h0;
        repeat (BIT_CLKS) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            rx <= d[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        if (use_par) begin
            rx <= par;
            repeat (BIT_CLKS) @(posedge clk);
        end
        rx <= stop;
        repeat (BIT_CLKS) @(posedge clk);
        rx <= 1'h1;
    endtask
    // Samples each bit at its centre, so a few cycles of start skew are harmless.
    task automatic get(output logic [7:0] d);
        int i;
        @(negedge clk);
        while (tx !== 1'h0) @(negedge clk);
        repeat (BIT_CLKS / 2) @(negedge clk);
        for (i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(negedge clk);
            d[i] = tx;
        end
    endtask
endmodule // upds_peer
`default_nettype wire

// ==== testbench/upds_assertions.sv ====
// Port-level checker for the serial port block.
`timescale 1ns/100ps
`default_nettype none
module upds_assertions (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    input wire logic TX_O,
    input wire logic TX_OE,
    input wire logic TX_PULLUP_EN,
    input wire logic SYNC_FUNC_EN,
    input wire logic [2:0] SYNC_MODE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // A start bit lasts at least eight clocks even at the fastest baud setting.
    sequence start_low;
        (!TX_O) [*7];
    endsequence
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    dat_quiet_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    dat_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper read bits set");
    tx_pull_a: assert property (TX_OE |-> !TX_PULLUP_EN)
        else $error("pull-high on driven pin");
    sync_excl_a: assert property (TX_OE |-> SYNC_MODE == 3'h0 && !SYNC_FUNC_EN)
        else $error("sync function active in async mode");
    start_len_a: assert property ($fell(TX_O) && TX_OE |=> start_low)
        else $error("start bit too short");
endmodule // upds_assertions
bind upds_top upds_assertions u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .TX_O(TX_O), .TX_OE(TX_OE),
    .TX_PULLUP_EN(TX_PULLUP_EN), .SYNC_FUNC_EN(SYNC_FUNC_EN), .SYNC_MODE(SYNC_MODE));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Register-level testbench for the serial port block.
`timescale 1ns/100ps
`default_nettype none
`include "upds_defs.vh"
module tb_top;
    logic clk, rst_b, cyc, stb, we;
    logic [7:0] adr, v;
    logic [3:0] sel;
    logic [31:0] wdat;
    wire logic [31:0] rdat;
    wire logic ack, irq, rx, tx, tx_oe, tx_pu, rx_pu, sfe;
    wire logic [2:0] smode;
    int n_errors, compares, i;
    logic [7:0] c1 [4] = '{8'h80, 8'hA0, 8'hB0, 8'h80};
    logic [7:0] est [4] = '{8'h0C, 8'h8C, 8'h0C, 8'h2C};
    logic pb [4] = '{1'h0, 1'h1, 1'h1, 1'h0};
    logic sb [4] = '{1'h1, 1'h1, 1'h1, 1'h0};
    upds_top uut (.REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .INT_O(irq),
        .RX_I(rx), .TX_O(tx), .TX_OE(tx_oe), .TX_PULLUP_EN(tx_pu), .RX_PULLUP_EN(rx_pu),
        .SYNC_FUNC_EN(sfe), .SYNC_MODE(smode));
    upds_peer #(.BIT_CLKS(16)) peer (.clk(clk), .tx(tx), .rx(rx));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'h1) @(posedge clk);
        v = rdat[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic settle;
        repeat (3) @(negedge clk);
    endtask
    // Runs beside a frame that the peer is sending, so the receiver is mid-character.
    task automatic peek_busy;
        repeat (40) @(posedge clk);
        wb(0, `UPDS_ADR_STAT, 0);
        chk(v & 8'h08, 8'h00);
    endtask
    initial begin
        {cyc, stb, we, adr, wdat, rst_b} = '0;
        sel = 4'h1;
        n_errors = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        settle;
        chk(smode, 3'h7);
        wb(0, `UPDS_ADR_MODE, 0); chk(v, 8'hE0);
        wb(0, `UPDS_ADR_STAT, 0); chk(v, 8'h00);
        wb(0, 8'h3C, 0); chk(v, 8'h00);
        wb(1, `UPDS_ADR_MODE, 8'h02); settle; chk(sfe, 1'h1);
        wb(1, `UPDS_ADR_MODE, 8'h10); settle; chk({sfe, smode}, 4'h0);
        wb(0, `UPDS_ADR_STAT, 0); chk(v, 8'h0B);
        wb(1, `UPDS_ADR_STAT, 8'hFF); wb(0, `UPDS_ADR_STAT, 0); chk(v, 8'h0B);
        wb(1, `UPDS_ADR_PULL, 8'h03); settle; chk({tx_oe, tx_pu, rx_pu}, 3'h3);
        wb(1, `UPDS_ADR_CTL1, 8'h80); wb(1, `UPDS_ADR_CTL2, 8'hC0); settle;
        chk({tx_oe, tx_pu, rx_pu}, 3'h4);
        wb(1, `UPDS_ADR_IRQM, 8'h04);
        wb(1, `UPDS_ADR_DATA, 8'hA5); peer.get(v); chk(v, 8'hA5);
        // Good frame, bad even parity, good odd parity, then a low stop bit.
        for (i = 0; i < 4; i++) begin
            wb(1, `UPDS_ADR_CTL1, c1[i]);
            peer.send(8'h3C, c1[i][5], pb[i], sb[i]);
            repeat (24) @(posedge clk);
            wb(0, `UPDS_ADR_STAT, 0); chk(v & 8'hFC, est[i]);
            wb(0, `UPDS_ADR_DATA, 0); chk(v, 8'h3C);
            wb(0, `UPDS_ADR_STAT, 0); chk(v & 8'hF4, 8'h00);
        end
        settle; chk(irq, 1'h1);
        wb(1, `UPDS_ADR_IRQS, 8'h04); settle; chk(irq, 1'h0);
        wb(1, `UPDS_ADR_IRQM, 8'h00);
        fork
            peer.send(8'h11, 0, 0, 1);
            peek_busy;
        join
        peer.send(8'h22, 0, 0, 1);
        repeat (24) @(posedge clk);
        wb(0, `UPDS_ADR_STAT, 0); chk(v & 8'hF4, 8'h14);
        wb(0, `UPDS_ADR_DATA, 0); chk(v, 8'h11);
        chk(irq, 1'h0);
        wb(0, `UPDS_ADR_STAT, 0); chk(v & 8'hF4, 8'h00);
        wb(1, `UPDS_ADR_MODE, 8'h00); settle; chk({tx_oe, tx_pu, rx_pu}, 3'h3);
        give_verdict;
    end
    // Roughly twenty times the expected run length.
    initial begin
        #1000000;
        n_errors++;
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
